// ### inc/cpld_pkg.sv
// Shared types and constants for the macrocell host access block.
// Assumes one 25 MHz system clock; all pins arrive asynchronously.
package cpld_pkg;
    typedef enum logic [1:0] {HOST_WR_RD_BHE, HOST_RW_DS_SIZ, HOST_WRL_RD_WRH} host_type_t;
    typedef enum logic [1:0] {IN_PASS, IN_LATCH, IN_REG} in_mode_t;

    localparam int CELL_COUNT = 16;
    localparam int GROUP_WIDTH = 8;
    localparam int IN_CELL_COUNT = 24;
    localparam int ECS_COUNT = 8;
    localparam int BUS_WIDTH = 16;
    localparam int NIBBLE_COUNT = 6;

    // Word offsets inside the io register space (address bits 7:1)
    localparam logic [6:0] OFS_IN_CELL_AB = 7'h0c;
    localparam logic [6:0] OFS_IN_CELL_C = 7'h0d;
    localparam logic [6:0] OFS_OUT_CELL = 7'h10;
    localparam logic [6:0] OFS_WRITE_MASK = 7'h11;

    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [15:0] BUS_RESET = 16'h0000;
    localparam logic [3:0] STROBE_IDLE = 4'hf;
    localparam logic [57:0] PIN_RESET = 58'h0;
endpackage

// ### src/out_cell.sv
// One output macrocell flip-flop (D type) with host load override.
// Assumes all enables are one-cycle pulses on the system clock.
module out_cell
    import cpld_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Host load
    input wire logic load_in,
    input wire logic load_data_in,
    // Array side
    input wire logic d_in,
    input wire logic preset_in,
    input wire logic clear_in,
    input wire logic clk_en_in,
    // Cell state
    output logic q_out
);
    logic q_ff;
    logic nxt_q;

    // Host load outranks preset, clear and clock
    assign nxt_q = load_in ? load_data_in :            // [RULE2]
                   preset_in ? 1'b1 :                  // [RULE24]
                   clear_in ? 1'b0 :
                   clk_en_in ? d_in : q_ff;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            q_ff <= 1'b0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign q_out = q_ff;

    property p_load_wins;
        @(posedge clk_sys_in) disable iff (rst_in)
        load_in |=> q_ff == $past(load_data_in);
    endproperty
    a_load_wins: assert property (p_load_wins) else $error("host load lost to array"); // [RULE2]

    property p_preset_high;
        @(posedge clk_sys_in) disable iff (rst_in)
        (!load_in && preset_in) |=> q_ff;
    endproperty
    a_preset_high: assert property (p_preset_high) else $error("preset did not set cell"); // [RULE24]
endmodule

// ### src/in_cell.sv
// One input macrocell: pass-through, transparent latch or register.
// Assumes the pin level is already synchronised to the system clock.
module in_cell
    import cpld_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Configuration
    input in_mode_t mode_in,
    // Pin and enable
    input wire logic pin_in,
    input wire logic en_level_in,
    input wire logic en_rise_in,
    // Cell output
    output logic q_out
);
    logic q_ff;
    logic nxt_q;
    logic take;

    assign take = (mode_in == IN_PASS) ||                   // [RULE11]
                  (mode_in == IN_LATCH && en_level_in) ||
                  (mode_in == IN_REG && en_rise_in);
    assign nxt_q = take ? pin_in : q_ff;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            q_ff <= 1'b0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign q_out = q_ff;

    property p_reg_holds;
        @(posedge clk_sys_in) disable iff (rst_in)
        (mode_in == IN_REG && !en_rise_in) |=> $stable(q_ff);
    endproperty
    a_reg_holds: assert property (p_reg_holds) else $error("register cell moved without clock"); // [RULE11]

    property p_pass_follows;
        @(posedge clk_sys_in) disable iff (rst_in)
        (mode_in == IN_PASS) |=> q_ff == $past(pin_in);
    endproperty
    a_pass_follows: assert property (p_pass_follows) else $error("pass cell did not follow pin"); // [RULE11]
endmodule

// ### src/cpld_macrocell_bus_access.sv
// Host access to output and input macrocells, chip selects and pin drivers.
// Assumes product terms and configuration come from logic on clk_sys_in;
// all pins, strobes and the shared bus are asynchronous and synchronised here.
// Functional notes
// RULE1 - Host loads all sixteen output cells from the bus and reads them back.
// RULE2 - A host load overrides cell preset, clear and clock.
// RULE3 - Load happens on the trailing edge of the write strobe.
// RULE4 - Two write-mask registers, one per group of eight output cells.
// RULE5 - Both masks reset to zero, allowing all loads.
// RULE6 - A set mask bit blocks host writes to its cell.
// RULE7 - Pin driver enable is output-enable term OR direction bit.
// RULE8 - Logic output without enable equation drives from power-up. Here its enable is low in reset and rises at the first clock after release.
// RULE9 - Internal node frees the pin but still feeds back to the array.
// RULE10 - Twenty-four input cells, one per pin of three ports.
// RULE11 - Each input cell is latch, register or pass-through.
// RULE12 - Input cell enable is chosen from a product term or address strobe.
// RULE13 - Input cell enable terms are shared per nibble.
// RULE14 - Host reads input cell outputs through a buffer.
// RULE15 - Input cells can capture address bits above fifteen with the strobe.
// RULE16 - Eight chip selects, each one term with selectable polarity.
// RULE17 - Chip select driver enabled by its enable term or direction bit.
// RULE18 - Control pins take meaning from host type; spare third pin is logic input.
// RULE19 - Multiplexed hosts must drive the address strobe; others may not.
// RULE20 - Multiplexed bus address is latched from the shared lines by the strobe.
// RULE21 - Shared bus driven only during a read of an own resource.
// RULE22 - Address lines beyond sixteen bits enter through port pins as logic inputs.
// RULE23 - Group A on bits 7:0, group B on 15:8; eight-bit mode uses 7:0. Here RW/DS hosts in 16-bit mode get the two groups swapped.
// RULE24 - External pin clock updates cells on its rising edge; preset/clear high.
// RULE25 - Write masks read back their last written value.
module cpld_macrocell_bus_access
    import cpld_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Host configuration
    input host_type_t host_type_in,
    input wire logic mux_bus_in,
    input wire logic eight_bit_in,
    input wire logic io_register_space_select_in,
    // Host control pins
    input wire logic ctrl_in_zero_in,
    input wire logic ctrl_in_one_in,
    input wire logic ctrl_in_two_in,
    input wire logic high_byte_write_pin_in,
    input wire logic addr_strobe_pin_in,
    input wire logic ext_clock_pin_in,
    // Host address and shared bus
    input wire logic [BUS_WIDTH-1:0] host_addr_in,
    input wire logic [BUS_WIDTH-1:0] shared_addr_data_port_in,
    output logic [BUS_WIDTH-1:0] shared_addr_data_port_out,
    output logic shared_addr_data_port_oe_out,
    // Output cell array terms
    input wire logic [CELL_COUNT-1:0] cell_d_in,
    input wire logic [CELL_COUNT-1:0] cell_preset_in,
    input wire logic [CELL_COUNT-1:0] cell_clear_in,
    input wire logic [CELL_COUNT-1:0] cell_clock_term_in,
    input wire logic [CELL_COUNT-1:0] cell_ext_clock_sel_in,
    input wire logic [CELL_COUNT-1:0] cell_oe_term_in,
    input wire logic [CELL_COUNT-1:0] cell_oe_defined_in,
    input wire logic [CELL_COUNT-1:0] cell_internal_node_in,
    input wire logic [CELL_COUNT-1:0] cell_direction_in,
    // Input cell configuration
    input in_mode_t in_mode_in [IN_CELL_COUNT],
    input wire logic [NIBBLE_COUNT-1:0] nibble_en_term_in,
    input wire logic [NIBBLE_COUNT-1:0] nibble_use_strobe_in,
    // Port pins
    input wire logic [IN_CELL_COUNT-1:0] port_pin_in,
    output logic [CELL_COUNT-1:0] port_pin_out,
    output logic [CELL_COUNT-1:0] port_pin_oe_out,
    // Chip selects
    input wire logic [ECS_COUNT-1:0] ecs_term_in,
    input wire logic [ECS_COUNT-1:0] ecs_active_low_in,
    input wire logic [ECS_COUNT-1:0] ecs_oe_term_in,
    input wire logic [ECS_COUNT-1:0] ecs_direction_in,
    output logic [ECS_COUNT-1:0] external_selects_out,
    output logic [ECS_COUNT-1:0] external_selects_oe_out,
    // Array feedback
    output logic [CELL_COUNT-1:0] cell_feedback_out,
    output logic [IN_CELL_COUNT-1:0] logic_input_bus_out,
    output logic spare_ctrl_logic_out
);
    // Two-stage synchronisers; stage one is read only by stage two
    logic [3:0] strobe_sync1_ff;
    logic [3:0] strobe_sync2_ff;
    logic [57:0] pin_sync1_ff;
    logic [57:0] pin_sync2_ff;
    logic [3:0] strobe_last_ff;
    logic [1:0] clk_last_ff;
    logic [BUS_WIDTH-1:0] addr_latch_ff;
    logic [GROUP_WIDTH-1:0] mask_a_ff;
    logic [GROUP_WIDTH-1:0] mask_b_ff;
    logic [BUS_WIDTH-1:0] bus_out_ff;
    logic bus_oe_ff;
    logic [CELL_COUNT-1:0] pin_out_ff;
    logic [CELL_COUNT-1:0] pin_oe_ff;
    logic [ECS_COUNT-1:0] ecs_ff;
    logic [ECS_COUNT-1:0] ecs_oe_ff;
    logic spare_ff;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            strobe_sync1_ff <= STROBE_IDLE;
            strobe_sync2_ff <= STROBE_IDLE;
            pin_sync1_ff <= PIN_RESET;
            pin_sync2_ff <= PIN_RESET;
        end else begin
            strobe_sync1_ff <= {high_byte_write_pin_in, ctrl_in_two_in, ctrl_in_one_in, ctrl_in_zero_in};
            strobe_sync2_ff <= strobe_sync1_ff;
            pin_sync1_ff <= {ext_clock_pin_in, addr_strobe_pin_in, host_addr_in, shared_addr_data_port_in,
                             port_pin_in};
            pin_sync2_ff <= pin_sync1_ff;
        end
    end

    // Synchronised pin views
    wire c0_n = strobe_sync2_ff[0];
    wire c1_n = strobe_sync2_ff[1];
    wire c2 = strobe_sync2_ff[2];
    wire hbw_n = strobe_sync2_ff[3];
    wire [IN_CELL_COUNT-1:0] ports_s = pin_sync2_ff[23:0];
    wire [BUS_WIDTH-1:0] bus_s = pin_sync2_ff[39:24];
    wire [BUS_WIDTH-1:0] haddr_s = pin_sync2_ff[55:40];
    wire ale_s = pin_sync2_ff[56];
    wire extclk_s = pin_sync2_ff[57];

    // Address: latched while strobe high on a multiplexed bus, live otherwise
    wire [BUS_WIDTH-1:0] nxt_addr_latch = ale_s ? bus_s : addr_latch_ff; // [RULE20]
    wire [BUS_WIDTH-1:0] addr = mux_bus_in ? addr_latch_ff : haddr_s;   // [RULE19]
    wire a0 = addr[0];
    wire [6:0] word_ofs = addr[7:1];

    // Control pin meaning per host type
    wire is_rwds = (host_type_in == HOST_RW_DS_SIZ);                    // [RULE18]
    wire is_wrh = (host_type_in == HOST_WRL_RD_WRH);
    wire byte_swap = is_rwds && !eight_bit_in;
    wire read_act = is_rwds ? (!c1_n && c0_n) : !c1_n;
    wire wlo_act = is_rwds ? (!c1_n && !c0_n) : (!c0_n && (is_wrh || !a0 || eight_bit_in));
    wire whi_act = is_rwds ? (!c1_n && !c0_n) : is_wrh ? !hbw_n : (!c0_n && !c2);
    wire bhe_used = (host_type_in == HOST_WR_RD_BHE) || is_rwds;
    wire [1:0] wr_act = {whi_act && !eight_bit_in, wlo_act};
    // Trailing edge of each lane's write strobe
    wire [1:0] wr_end = strobe_last_ff[1:0] & ~wr_act;                  // [RULE3]

    // Register select within io space
    wire sel = io_register_space_select_in;
    wire hit_out = sel && (word_ofs == OFS_OUT_CELL);
    wire hit_mask = sel && (word_ofs == OFS_WRITE_MASK);
    wire hit_in_ab = sel && (word_ofs == OFS_IN_CELL_AB);
    wire hit_in_c = sel && (word_ofs == OFS_IN_CELL_C);
    wire own_hit = hit_out || hit_mask || hit_in_ab || hit_in_c;

    // Lane routing: group A on low byte unless swapped; 8-bit uses low lane only
    wire [7:0] lane_lo = bus_s[7:0];
    wire [7:0] lane_hi = bus_s[15:8];
    wire [7:0] data_a = byte_swap ? lane_hi : lane_lo;                   // [RULE23]
    wire [7:0] data_b = (byte_swap || eight_bit_in) ? lane_lo : lane_hi;
    wire load_a_ev = eight_bit_in ? (wr_end[0] && !a0) : (byte_swap ? wr_end[1] : wr_end[0]);
    wire load_b_ev = eight_bit_in ? (wr_end[0] && a0) : (byte_swap ? wr_end[0] : wr_end[1]);

    // Masked per-cell host loads
    wire [CELL_COUNT-1:0] load_vec = {{GROUP_WIDTH{hit_out && load_b_ev}} & ~mask_b_ff,
                                      {GROUP_WIDTH{hit_out && load_a_ev}} & ~mask_a_ff}; // [RULE6]
    wire [CELL_COUNT-1:0] load_data = {data_b, data_a};

    // Clock events: array term edge or synchronised pin clock rise
    logic [CELL_COUNT-1:0] term_last_ff;
    wire ext_rise = extclk_s && !clk_last_ff[0];                         // [RULE24]
    wire [CELL_COUNT-1:0] term_rise = cell_clock_term_in & ~term_last_ff;
    wire [CELL_COUNT-1:0] cell_clk_en = (cell_ext_clock_sel_in & {CELL_COUNT{ext_rise}}) |
                                        (~cell_ext_clock_sel_in & term_rise);
    wire [CELL_COUNT-1:0] cell_q;

    genvar gi;
    generate
        for (gi = 0; gi < CELL_COUNT; gi++) begin : g_out
            out_cell u_out_cell (
                .clk_sys_in(clk_sys_in),
                .rst_in(rst_in),
                .load_in(load_vec[gi]),                                  // [RULE1]
                .load_data_in(load_data[gi]),
                .d_in(cell_d_in[gi]),
                .preset_in(cell_preset_in[gi]),
                .clear_in(cell_clear_in[gi]),
                .clk_en_in(cell_clk_en[gi]),
                .q_out(cell_q[gi])
            );
        end
    endgenerate

    // Input cells with per-nibble enable source
    logic [NIBBLE_COUNT-1:0] en_last_ff;
    wire [NIBBLE_COUNT-1:0] nib_en = (nibble_use_strobe_in & {NIBBLE_COUNT{ale_s}}) |
                                     (~nibble_use_strobe_in & nibble_en_term_in); // [RULE12]
    wire [NIBBLE_COUNT-1:0] nib_rise = nib_en & ~en_last_ff;
    wire [IN_CELL_COUNT-1:0] in_q;

    generate
        for (gi = 0; gi < IN_CELL_COUNT; gi++) begin : g_in
            in_cell u_in_cell (
                .clk_sys_in(clk_sys_in),
                .rst_in(rst_in),
                .mode_in(in_mode_in[gi]),                                 // [RULE10]
                .pin_in(ports_s[gi]),                                     // [RULE15] [RULE22]
                .en_level_in(nib_en[gi/4]),                               // [RULE13]
                .en_rise_in(nib_rise[gi/4]),
                .q_out(in_q[gi])
            );
        end
    endgenerate

    // Read data, ordered as group A low, group B high before lane mapping
    wire [BUS_WIDTH-1:0] rd_word = hit_out ? cell_q :                     // [RULE1]
                                   hit_mask ? {mask_b_ff, mask_a_ff} :     // [RULE25]
                                   hit_in_ab ? in_q[15:0] :                // [RULE14]
                                   hit_in_c ? {8'h00, in_q[23:16]} : BUS_RESET;
    wire [BUS_WIDTH-1:0] rd_lanes = eight_bit_in ? {8'h00, (a0 ? rd_word[15:8] : rd_word[7:0])} :
                                    byte_swap ? {rd_word[7:0], rd_word[15:8]} : rd_word;
    wire drive_bus = own_hit && read_act && !(mux_bus_in && ale_s);       // [RULE21]

    // Pin and chip select driver enables
    wire [CELL_COUNT-1:0] nxt_pin_oe = ~cell_internal_node_in &           // [RULE9]
                                       (~cell_oe_defined_in | cell_oe_term_in | cell_direction_in); // [RULE7] [RULE8]
    wire [ECS_COUNT-1:0] nxt_ecs = ecs_term_in ^ ecs_active_low_in;       // [RULE16]
    wire [ECS_COUNT-1:0] nxt_ecs_oe = ecs_oe_term_in | ecs_direction_in;  // [RULE17]
    wire mask_a_wr = hit_mask && load_a_ev;
    wire mask_b_wr = hit_mask && load_b_ev;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            strobe_last_ff <= 4'h0;
            clk_last_ff <= 2'h0;
            term_last_ff <= '0;
            en_last_ff <= '0;
            addr_latch_ff <= BUS_RESET;
        end else begin
            strobe_last_ff <= {2'h0, wr_act};
            clk_last_ff <= {1'b0, extclk_s};
            term_last_ff <= cell_clock_term_in;
            en_last_ff <= nib_en;
            addr_latch_ff <= nxt_addr_latch;
        end
    end

    // Write masks, loaded on the same trailing edge as the cells
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            mask_a_ff <= MASK_RESET;                                      // [RULE5]
            mask_b_ff <= MASK_RESET;
        end else begin
            if (mask_a_wr) begin
                mask_a_ff <= data_a;                                      // [RULE4]
            end
            if (mask_b_wr) begin
                mask_b_ff <= data_b;
            end
        end
    end

    // Registered pin outputs; enables start low and settle one edge after release
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            bus_out_ff <= BUS_RESET;
            bus_oe_ff <= 1'b0;
            pin_out_ff <= '0;
            pin_oe_ff <= '0;
            ecs_ff <= '0;
            ecs_oe_ff <= '0;
            spare_ff <= 1'b0;
        end else begin
            bus_out_ff <= rd_lanes;
            bus_oe_ff <= drive_bus;
            pin_out_ff <= cell_q;
            pin_oe_ff <= nxt_pin_oe;
            ecs_ff <= nxt_ecs;
            ecs_oe_ff <= nxt_ecs_oe;
            spare_ff <= c2 && !bhe_used;                                  // [RULE18]
        end
    end

    assign shared_addr_data_port_out = bus_out_ff;
    assign shared_addr_data_port_oe_out = bus_oe_ff;
    assign port_pin_out = pin_out_ff;
    assign port_pin_oe_out = pin_oe_ff;
    assign external_selects_out = ecs_ff;
    assign external_selects_oe_out = ecs_oe_ff;
    assign logic_input_bus_out = in_q;
    // Feedback is kept even for internal nodes; the pin is what is freed
    assign cell_feedback_out = cell_q;                                    // [RULE9]
    assign spare_ctrl_logic_out = spare_ff;

    property p_mask_reset;
        @(posedge clk_sys_in)
        $fell(rst_in) |-> (mask_a_ff == 8'h00 && mask_b_ff == 8'h00);
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("masks not clear after reset"); // [RULE5]

    property p_masked_hold;
        @(posedge clk_sys_in) disable iff (rst_in)
        (hit_out && load_a_ev && mask_a_ff[0] && !cell_preset_in[0] && !cell_clear_in[0] && !cell_clk_en[0])
            |=> $stable(cell_q[0]);
    endproperty
    a_masked_hold: assert property (p_masked_hold) else $error("masked cell was loaded"); // [RULE6]

    property p_trailing_load;
        @(posedge clk_sys_in) disable iff (rst_in)
        (hit_out && load_a_ev && !mask_a_ff[3]) |=> cell_q[3] == $past(data_a[3]);
    endproperty
    a_trailing_load: assert property (p_trailing_load) else $error("write end did not load cell"); // [RULE3]

    property p_mask_readback;
        @(posedge clk_sys_in) disable iff (rst_in)
        (mask_a_wr && !eight_bit_in && !byte_swap) ##1 (hit_mask && !mask_a_wr) |=> bus_out_ff[7:0] == mask_a_ff;
    endproperty
    a_mask_readback: assert property (p_mask_readback) else $error("mask readback wrong"); // [RULE25]

    property p_bus_only_on_read;
        @(posedge clk_sys_in) disable iff (rst_in)
        bus_oe_ff |-> $past(own_hit && read_act);
    endproperty
    a_bus_only_on_read: assert property (p_bus_only_on_read) else $error("bus driven outside read"); // [RULE21]

    property p_bus_release;
        @(posedge clk_sys_in) disable iff (rst_in)
        !read_act ##1 !read_act |-> !bus_oe_ff;
    endproperty
    a_bus_release: assert property (p_bus_release) else $error("bus not released"); // [RULE21]

    property p_ecs_polarity;
        @(posedge clk_sys_in) disable iff (rst_in)
        ##1 ecs_ff == ($past(ecs_term_in) ^ $past(ecs_active_low_in));
    endproperty
    a_ecs_polarity: assert property (p_ecs_polarity) else $error("chip select polarity wrong"); // [RULE16]

    property p_pin_oe;
        @(posedge clk_sys_in) disable iff (rst_in)
        (!cell_internal_node_in[0] && cell_direction_in[0]) |=> pin_oe_ff[0];
    endproperty
    a_pin_oe: assert property (p_pin_oe) else $error("direction bit did not enable pin"); // [RULE7]

    property p_node_free;
        @(posedge clk_sys_in) disable iff (rst_in)
        cell_internal_node_in[1] |=> !pin_oe_ff[1];
    endproperty
    a_node_free: assert property (p_node_free) else $error("internal node drove pin"); // [RULE9]
endmodule

// ### test/host_model.sv
// Host model: non-multiplexed bus with write, read and byte-high strobes.
// Assumes the bench calls wr and rd; pins change 1 ns after a clock edge.
module host_model
    import cpld_pkg::*;
(
    // Clock
    input wire logic clk_sys_in,
    // Device side of the shared bus
    input wire logic [15:0] dev_data_in,
    input wire logic dev_oe_in,
    // Host pins
    output logic wr_n_out,
    output logic rd_n_out,
    output logic bhe_n_out,
    output logic [15:0] addr_out,
    output logic [15:0] bus_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic drive = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] last_ff = 16'h0000;
    initial begin
        wr_n_out = 1'b1;
        rd_n_out = 1'b1;
        bhe_n_out = 1'b1;
        addr_out = 16'h0000;
    end
    // Released bus toggles so a stale value never reads as valid
    assign bus_out = drive ? wdata : (dev_oe_in ? dev_data_in : ~last_ff);
    always @(posedge clk_sys_in) last_ff <= bus_out;
    // Write: strobe, byte-high and data held past the strobe end
    task automatic wr(input logic [6:0] ofs, input logic [15:0] d);
        @(posedge clk_sys_in);
        #1 addr_out = {8'h00, ofs, 1'b0};
        wdata = d;
        drive = 1'b1;
        bhe_n_out = 1'b0;
        wr_n_out = 1'b0;
        repeat (6) @(posedge clk_sys_in);
        #1 wr_n_out = 1'b1;
        repeat (4) @(posedge clk_sys_in);
        #1 drive = 1'b0;
        bhe_n_out = 1'b1;
        repeat (4) @(posedge clk_sys_in);
    endtask
    // Read: strobe held long enough for the 3-clock answer
    task automatic rd(input logic [6:0] ofs);
        @(posedge clk_sys_in);
        #1 addr_out = {8'h00, ofs, 1'b0};
        bhe_n_out = 1'b0;
        rd_n_out = 1'b0;
        repeat (6) @(posedge clk_sys_in);
        #1 rd_n_out = 1'b1;
        bhe_n_out = 1'b1;
        repeat (5) @(posedge clk_sys_in);
    endtask
endmodule

// ### test/cpld_macrocell_bus_access_tb_top.sv
// Bench for host access to macrocells, chip selects and pin drivers.
// Assumes a non-multiplexed host of the write/read/byte-high type.
module cpld_macrocell_bus_access_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import cpld_pkg::*;
    logic clk = 1'b0, rst = 1'b1, wr_n, rd_n, bhe_n, oe, oe_q = 1'b0, sel = 1'b1, ale = 1'b0, ext = 1'b0, spare;
    logic [15:0] clr = 16'h0000, extsel = 16'h0000, fand = 16'hffff;
    logic [15:0] addr, bus_in, bus_out, d, d2, rnd = 16'h0036, ppo, ppoe, fb, q[$];
    logic [15:0] preset = 16'h0000, oe_term = 16'h0000, oe_def = 16'h0000, inode = 16'h0000, dir = 16'h0000;
    logic [23:0] pins = 24'h000000, pins_old, libus;
    logic [7:0] e_t = 8'h00, e_al = 8'h00, e_oe = 8'h00, e_dir = 8'h00, es, es_oe;
    logic [5:0] nib = 6'h00, nibstr = 6'h00;
    in_mode_t modes [IN_CELL_COUNT];
    int failures = 0, n_tests = 0;
    initial forever #20 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (failures == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    host_model host (.clk_sys_in(clk), .dev_data_in(bus_out), .dev_oe_in(oe), .wr_n_out(wr_n), .rd_n_out(rd_n),
        .bhe_n_out(bhe_n), .addr_out(addr), .bus_out(bus_in));
    // Non-multiplexed host: address from host_addr_in, strobe only clocks input cells
    cpld_macrocell_bus_access dut (.clk_sys_in(clk), .rst_in(rst), .host_type_in(HOST_WR_RD_BHE), .mux_bus_in(1'b0),
        .eight_bit_in(1'b0), .io_register_space_select_in(sel), .ctrl_in_zero_in(wr_n), .ctrl_in_one_in(rd_n),
        .ctrl_in_two_in(bhe_n), .high_byte_write_pin_in(1'b1), .addr_strobe_pin_in(ale), .ext_clock_pin_in(ext),
        .host_addr_in(addr), .shared_addr_data_port_in(bus_in), .shared_addr_data_port_out(bus_out),
        .shared_addr_data_port_oe_out(oe), .cell_d_in(rnd), .cell_preset_in(preset), .cell_clear_in(clr),
        .cell_clock_term_in(16'h0000), .cell_ext_clock_sel_in(extsel), .cell_oe_term_in(oe_term),
        .cell_oe_defined_in(oe_def), .cell_internal_node_in(inode), .cell_direction_in(dir), .in_mode_in(modes),
        .nibble_en_term_in(nib), .nibble_use_strobe_in(nibstr), .port_pin_in(pins), .port_pin_out(ppo),
        .port_pin_oe_out(ppoe), .ecs_term_in(e_t), .ecs_active_low_in(e_al), .ecs_oe_term_in(e_oe),
        .ecs_direction_in(e_dir), .external_selects_out(es), .external_selects_oe_out(es_oe),
        .cell_feedback_out(fb), .logic_input_bus_out(libus), .spare_ctrl_logic_out(spare));
    // Read data is judged at the first edge its enable is seen high
    always @(posedge clk) begin
        if (oe === 1'b1 && oe_q !== 1'b1) begin
            if (q.size() == 0) check(bus_out, 16'hxxxx);
            else check(bus_out, q.pop_front());
        end
        oe_q <= oe;
        // Sticky AND catches a one-cycle dip that a later look would miss
        fand <= fand & fb;
    end
    initial begin
        #800000 failures++;
        stop_test();
    end
    initial begin
        foreach (modes[i]) modes[i] = IN_PASS;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk);
        #1 check(ppoe, 16'hffff);
        q.push_back(16'h0000);
        host.rd(OFS_WRITE_MASK);
        rnd = lfsr(rnd);
        d = rnd;
        host.wr(OFS_OUT_CELL, d);
        q.push_back(d);
        host.rd(OFS_OUT_CELL);
        #1 check(ppo, d);
        host.wr(OFS_WRITE_MASK, 16'h0f0f);
        q.push_back(16'h0f0f);
        host.rd(OFS_WRITE_MASK);
        host.wr(OFS_OUT_CELL, 16'h0000);
        #1 check(fb, d & 16'h0f0f);
        preset = 16'hffff;
        @(posedge clk);
        #1 fand = 16'hffff;
        // Load must beat a held preset: unmasked cells dip to zero for one cycle
        host.wr(OFS_OUT_CELL, 16'h0000);
        #1 check(fand, 16'h0f0f);
        {preset, clr} = {16'h0000, 16'hffff};
        repeat (2) @(posedge clk);
        #1 check(fb, 16'h0000);
        clr = 16'h0000;
        host.wr(OFS_WRITE_MASK, 16'h0000);
        rnd = lfsr(rnd);
        d2 = rnd;
        host.wr(OFS_OUT_CELL, d2);
        q.push_back(d2);
        host.rd(OFS_OUT_CELL);
        #1 check({15'h0000, oe}, 16'h0000);
        rnd = lfsr(rnd);
        pins = {rnd[7:0], ~rnd};
        repeat (4) @(posedge clk);
        q.push_back(pins[15:0]);
        host.rd(OFS_IN_CELL_AB);
        q.push_back({8'h00, pins[23:16]});
        host.rd(OFS_IN_CELL_C);
        #1 check(libus[15:0], pins[15:0]);
        #1 {e_t, e_al} = lfsr(rnd);
        {e_oe, e_dir} = rnd;
        oe_def = 16'hff0f;
        oe_term = lfsr(rnd);
        dir = rnd;
        inode = 16'h00f0;
        repeat (3) @(posedge clk);
        #1 check({8'h00, es}, {8'h00, e_t ^ e_al});
        check({8'h00, es_oe}, {8'h00, e_oe | e_dir});
        check(ppoe, ~inode & (~oe_def | oe_term | dir));
        check(fb, d2);
        check({15'h0000, spare}, 16'h0000);
        {extsel, rnd} = {16'hffff, lfsr(rnd)};
        ext = 1'b1;
        repeat (4) @(posedge clk);
        #1 check(fb, rnd);
        sel = 1'b0;
        // No note queued: any drive while deselected is a mismatch
        host.rd(OFS_OUT_CELL);
        #1 sel = 1'b1;
        foreach (modes[i]) modes[i] = (i < 12) ? IN_LATCH : IN_REG;
        {nibstr, pins_old} = {6'h3f, pins};
        pins = ~pins;
        repeat (4) @(posedge clk);
        #1 check(libus[15:0], pins_old[15:0]);
        ale = 1'b1;
        repeat (4) @(posedge clk);
        #1 check(libus[15:0], pins[15:0]);
        check({8'h00, libus[23:16]}, {8'h00, pins[23:16]});
        {ale, nibstr, nib, pins} = {1'b0, 6'h00, 6'h01, pins_old};
        repeat (4) @(posedge clk);
        #1 check(libus[15:0], {~pins_old[15:4], pins_old[3:0]});
        for (int i = 0; i < 20 && q.size() > 0; i++) @(posedge clk);
        if (q.size() > 0) failures++;
        stop_test();
    end
endmodule
